// file: hw/cmd_timing_guard.v
// host-side command timing guard for a DDR4 memory device
`timescale 1ns/100ps
`include "cmd_timing_consts.vh"
// Function
// - wait mode update delay after any MRS
// - first strobe edge 40 cycles after leveling
// - strobe drive enable after 25 cycles
// - issue deselects within 78/85 cycles of alert
// - refresh cycle time per granularity mode
// - reads wait for locked delay loop
// - write recovery ns rounded up to cycles
// - auto-precharge uses programmed recovery cycles
// - ns parameters rounded up to cycles
// - use CRC-plus-mask delays for WR (not WRA) when both enabled
module cmd_timing_guard (
	input  wire                mclk_in,
	input  wire                rst_in,
	input  wire                cmd_valid_in,
	input  wire [`CMD_W-1:0]   cmd_in,
	input  wire                wlvl_mrs_in,
	input  wire                grade_3200_in,
	input  wire [1:0]          fgr_mode_in,
	input  wire                persist_par_in,
	input  wire                crc_dm_in,
	input  wire [7:0]          wr_ns_in,
	input  wire [7:0]          wr_crc_dm_ns_in,
	input  wire [5:0]          wr_mr_cyc_in,
	input  wire [5:0]          wl_cyc_in,
	input  wire                bc4_fixed_in,
	input  wire                dll_relock_in,
	input  wire                alert_n_in,
	output wire                cmd_ready_out,
	output wire                cmd_issue_out,
	output reg                 deselect_out,
	output reg                 dqs_drive_en_out,
	output reg                 dqs_edge_ok_out,
	output reg                 par_rsp_late_out
);
	// refresh spacing in whole clock cycles, rounded up
	localparam integer RFC1_FULL = (`T_RFC1_NS * 32'h3E8 + `CLK_PERIOD_PS - 32'h1) / `CLK_PERIOD_PS;
	localparam integer RFC2_FULL = (`T_RFC2_NS * 32'h3E8 + `CLK_PERIOD_PS - 32'h1) / `CLK_PERIOD_PS;
	localparam integer RFC4_FULL = (`T_RFC4_NS * 32'h3E8 + `CLK_PERIOD_PS - 32'h1) / `CLK_PERIOD_PS;
	localparam [`CNT_W-1:0] RFC1_CYC = RFC1_FULL[`CNT_W-1:0];
	localparam [`CNT_W-1:0] RFC2_CYC = RFC2_FULL[`CNT_W-1:0];
	localparam [`CNT_W-1:0] RFC4_CYC = RFC4_FULL[`CNT_W-1:0];
	localparam ST_RUN   = 2'h0;
	localparam ST_ALERT = 2'h1;

	// round a ns figure up to whole clock cycles
	function [`CNT_W-1:0] ns_to_cyc;
		input [7:0] ns;
		reg [31:0] t;
		begin
			t = ({24'h0, ns} * 32'h3E8 + `CLK_PERIOD_PS - 32'h1) / `CLK_PERIOD_PS;
			ns_to_cyc = t[`CNT_W-1:0];
		end
	endfunction

	// true when command k is being issued this cycle
	function issued;
		input              go;
		input [`CMD_W-1:0] c;
		input [`CMD_W-1:0] k;
		begin
			issued = go & (c == k);
		end
	endfunction

	reg  [`CNT_W-1:0] mod_cnt_reg;
	reg  [`CNT_W-1:0] rfc_cnt_reg;
	reg  [`CNT_W-1:0] wl_cnt_reg;
	reg  [`CNT_W-1:0] dll_cnt_reg;
	reg  [`CNT_W-1:0] pd_cnt_reg;
	reg  [`CNT_W-1:0] rsp_cnt_reg;
	reg  [1:0]        state_reg;
	reg               alert_d_reg;
	reg               wl_act_reg;
	reg  [`CNT_W-1:0] rfc_sel;
	reg  [`CNT_W-1:0] wr_cyc;
	reg  [`CNT_W-1:0] pd_next;
	reg               blocked;
	wire              alert_rise = ~alert_n_in & alert_d_reg;
	wire [`CNT_W-1:0] rsp_lim = grade_3200_in ? `PAR_RSP_3200_CYC : `PAR_RSP_2933_CYC;

	always @* begin
		case (fgr_mode_in)
			`FGR_2X: rfc_sel = RFC2_CYC;
			`FGR_4X: rfc_sel = RFC4_CYC;
			default: rfc_sel = RFC1_CYC;
		endcase
		wr_cyc = crc_dm_in ? ns_to_cyc(wr_crc_dm_ns_in) : ns_to_cyc(wr_ns_in);
		// internal write start offset then recovery
		pd_next = {4'h0, wl_cyc_in} + (bc4_fixed_in ? 10'h002 : 10'h004) + wr_cyc;
		if (cmd_in == `CMD_WRA)
			pd_next = {4'h0, wl_cyc_in} + (bc4_fixed_in ? 10'h002 : 10'h004)
				+ {4'h0, wr_mr_cyc_in} + 10'h001;
		blocked = 1'b0;
		if (state_reg == ST_ALERT && persist_par_in)
			blocked = 1'b1;
		if (mod_cnt_reg != 10'h000 && cmd_in != `CMD_MRS)
			blocked = 1'b1;
		if (rfc_cnt_reg != 10'h000 && (cmd_in == `CMD_ACT || cmd_in == `CMD_REF))
			blocked = 1'b1;
		if (dll_cnt_reg != 10'h000 && cmd_in == `CMD_RD)
			blocked = 1'b1;
		if (pd_cnt_reg != 10'h000 && cmd_in == `CMD_PDE)
			blocked = 1'b1;
	end

	assign cmd_ready_out = ~blocked;
	assign cmd_issue_out = cmd_valid_in & ~blocked & (cmd_in != `CMD_NOP);

	// refresh, mode update and power-down spacing counters
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mod_cnt_reg <= 10'h000;
			rfc_cnt_reg <= 10'h000;
			pd_cnt_reg  <= 10'h000;
		end else begin
			if (issued(cmd_issue_out, cmd_in, `CMD_MRS))
				mod_cnt_reg <= `T_MOD_CYC;
			else if (mod_cnt_reg != 10'h000)
				mod_cnt_reg <= mod_cnt_reg - 10'h001;
			if (issued(cmd_issue_out, cmd_in, `CMD_REF))
				rfc_cnt_reg <= rfc_sel;
			else if (rfc_cnt_reg != 10'h000)
				rfc_cnt_reg <= rfc_cnt_reg - 10'h001;
			if (issued(cmd_issue_out, cmd_in, `CMD_WR))
				pd_cnt_reg <= pd_next;
			else if (issued(cmd_issue_out, cmd_in, `CMD_WRA))
				pd_cnt_reg <= pd_next;
			else if (pd_cnt_reg != 10'h000)
				pd_cnt_reg <= pd_cnt_reg - 10'h001;
		end
	end

	// delay loop relock hold-off for reads
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			dll_cnt_reg <= 10'h000;
		else if (dll_relock_in)
			dll_cnt_reg <= `DLL_LOCK_CYC;
		else if (dll_cnt_reg != 10'h000)
			dll_cnt_reg <= dll_cnt_reg - 10'h001;
	end

	// write leveling strobe timing
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wl_act_reg       <= 1'b0;
			wl_cnt_reg       <= 10'h000;
			dqs_drive_en_out <= 1'b0;
			dqs_edge_ok_out  <= 1'b0;
		end else if (issued(cmd_issue_out, cmd_in, `CMD_MRS) && wlvl_mrs_in) begin
			wl_act_reg       <= 1'b1;
			wl_cnt_reg       <= 10'h000;
			dqs_drive_en_out <= 1'b0;
			dqs_edge_ok_out  <= 1'b0;
		end else if (wl_act_reg) begin
			if (wl_cnt_reg != `T_WLMRD_CYC)
				wl_cnt_reg <= wl_cnt_reg + 10'h001;
			if (wl_cnt_reg + 10'h001 >= `T_WLDQSEN_CYC)
				dqs_drive_en_out <= 1'b1;
			if (wl_cnt_reg + 10'h001 >= `T_WLMRD_CYC)
				dqs_edge_ok_out <= 1'b1;
			if (issued(cmd_issue_out, cmd_in, `CMD_MRS)) begin
				wl_act_reg       <= 1'b0;
				dqs_drive_en_out <= 1'b0;
				dqs_edge_ok_out  <= 1'b0;
			end
		end
	end

	// parity alert response, device drops commands meanwhile
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alert_d_reg      <= 1'b1;
			state_reg        <= ST_RUN;
			rsp_cnt_reg      <= 10'h000;
			deselect_out     <= 1'b0;
			par_rsp_late_out <= 1'b0;
		end else begin
			alert_d_reg <= alert_n_in;
			case (state_reg)
				ST_RUN: begin
					deselect_out <= 1'b0;
					if (alert_rise) begin
						state_reg    <= ST_ALERT;
						rsp_cnt_reg  <= 10'h000;
						deselect_out <= persist_par_in;
					end
				end
				ST_ALERT: begin
					if (rsp_cnt_reg != rsp_lim)
						rsp_cnt_reg <= rsp_cnt_reg + 10'h001;
					if (!deselect_out && persist_par_in && rsp_cnt_reg >= rsp_lim)
						par_rsp_late_out <= 1'b1;
					if (!persist_par_in)
						deselect_out <= 1'b0;
					if (alert_n_in) begin
						state_reg    <= ST_RUN;
						deselect_out <= 1'b0;
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end
endmodule // cmd_timing_guard

// file: inc/cmd_timing_consts.vh
// timing constants for the memory command timing checker
`ifndef CMD_TIMING_CONSTS_VH
`define CMD_TIMING_CONSTS_VH
`define CLK_PERIOD_PS      32'h4E20
`define T_RFC1_NS          32'h15E
`define T_RFC2_NS          32'h104
`define T_RFC4_NS          32'h0A0
`define T_MOD_CYC          10'h018
`define T_WLMRD_CYC        10'h028
`define T_WLDQSEN_CYC      10'h019
`define PAR_RSP_2933_CYC   10'h04E
`define PAR_RSP_3200_CYC   10'h055
`define DLL_LOCK_CYC       10'h300
`define CNT_W              10
`define CMD_W              3
`define CMD_NOP            3'h0
`define CMD_MRS            3'h1
`define CMD_REF            3'h2
`define CMD_ACT            3'h3
`define CMD_RD             3'h4
`define CMD_WR             3'h5
`define CMD_WRA            3'h6
`define CMD_PDE            3'h7
`define FGR_1X             2'h0
`define FGR_2X             2'h1
`define FGR_4X             2'h2
`endif

// file: verif/ddr4_device_model.sv
// device model: drives the alert line after injected errors
`timescale 1ns/100ps
module ddr4_device_model (
	input  wire mclk_in,
	input  wire rst_in,
	input  wire par_err_in,
	input  wire crc_err_in,
	output wire alert_n_out
);
	reg [7:0] left_reg;
	assign #5 alert_n_out = (left_reg == 8'h00);
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			left_reg <= 8'h00;
		else if (par_err_in)
			left_reg <= 8'h58;
		else if (crc_err_in)
			left_reg <= 8'h06;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
	end
endmodule // ddr4_device_model

// file: verif/cmd_timing_guard_assertions.sv
// checker for the command timing guard ports
`timescale 1ns/100ps
`include "cmd_timing_consts.vh"
module cmd_timing_guard_assertions (
	input wire              mclk_in,
	input wire              rst_in,
	input wire              cmd_valid_in,
	input wire              wlvl_mrs_in,
	input wire              persist_par_in,
	input wire              dll_relock_in,
	input wire              alert_n_in,
	input wire              cmd_ready_out,
	input wire              cmd_issue_out,
	input wire              deselect_out,
	input wire              dqs_drive_en_out,
	input wire              dqs_edge_ok_out,
	input wire              par_rsp_late_out,
	input wire [`CMD_W-1:0] cmd_in,
	input wire [1:0]        fgr_mode_in
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire mrs_go = cmd_issue_out && cmd_in == `CMD_MRS;
	property p_iss; cmd_issue_out |-> cmd_valid_in && cmd_ready_out && cmd_in != `CMD_NOP; endproperty
	a_iss: assert property (p_iss) else $error("issue without request");
	property p_ref; cmd_issue_out && cmd_in == `CMD_REF && fgr_mode_in == `FGR_1X
		|=> !(cmd_issue_out && (cmd_in == `CMD_REF || cmd_in == `CMD_ACT)) [*8]; endproperty
	a_ref: assert property (p_ref) else $error("refresh spacing broken");
	property p_mrs; mrs_go |=> !(cmd_issue_out && cmd_in != `CMD_MRS) [*8]; endproperty
	a_mrs: assert property (p_mrs) else $error("command too soon after mode set");
	property p_lvl; mrs_go && wlvl_mrs_in |=> !dqs_drive_en_out [*8]; endproperty
	a_lvl: assert property (p_lvl) else $error("strobe drive too early");
	property p_edge; $rose(dqs_edge_ok_out) |-> $past(dqs_drive_en_out, 8); endproperty
	a_edge: assert property (p_edge) else $error("strobe edge before drive");
	property p_des; persist_par_in && $fell(alert_n_in) |=> deselect_out; endproperty
	a_des: assert property (p_des) else $error("no deselect on alert");
	property p_hold; deselect_out |-> !cmd_ready_out && !cmd_issue_out; endproperty
	a_hold: assert property (p_hold) else $error("command during deselect");
	property p_dll; dll_relock_in |=> !(cmd_issue_out && cmd_in == `CMD_RD) [*8]; endproperty
	a_dll: assert property (p_dll) else $error("read while loop relocks");
	property p_late; par_rsp_late_out |=> par_rsp_late_out; endproperty
	a_late: assert property (p_late) else $error("late flag dropped");
	c_lvl: cover property (mrs_go && wlvl_mrs_in);
	c_des: cover property ($rose(deselect_out));
	c_pde: cover property (cmd_issue_out && cmd_in == `CMD_PDE);
endmodule // cmd_timing_guard_assertions

// file: verif/cmd_timing_guard_tb_top.sv
// testbench for the command timing guard
`timescale 1ns/100ps
`include "cmd_timing_consts.vh"
module cmd_timing_guard_tb_top;
	reg mclk_in = 0, rst_in = 1, cmd_valid_in = 0, wlvl_mrs_in = 0, grade_3200_in = 0;
	reg persist_par_in = 0, crc_dm_in = 0, bc4_fixed_in = 0, dll_relock_in = 0, par = 0, crc = 0;
	reg [2:0] cmd_in = 0;
	reg [1:0] fgr_mode_in = 0;
	reg [7:0] wr_ns_in = 8'h1E, wr_crc_dm_ns_in = 8'h2D;
	reg [5:0] wr_mr_cyc_in = 6'h05, wl_cyc_in = 6'h0A;
	wire alert_n_in, cmd_ready_out, cmd_issue_out, deselect_out;
	wire dqs_drive_en_out, dqs_edge_ok_out, par_rsp_late_out;
	wire [4:0] sig = {~deselect_out, deselect_out, dqs_edge_ok_out, dqs_drive_en_out, cmd_ready_out};
	localparam [39:0] PDX = {8'h12, 8'h14, 8'h11, 8'h0E, 8'h10};
	integer num_errors = 0, checks = 0, n, i;
	always #10 mclk_in = ~mclk_in;
	cmd_timing_guard dut (.mclk_in, .rst_in, .cmd_valid_in, .cmd_in, .wlvl_mrs_in,
		.grade_3200_in, .fgr_mode_in, .persist_par_in, .crc_dm_in, .wr_ns_in,
		.wr_crc_dm_ns_in, .wr_mr_cyc_in, .wl_cyc_in, .bc4_fixed_in, .dll_relock_in,
		.alert_n_in, .cmd_ready_out, .cmd_issue_out, .deselect_out, .dqs_drive_en_out,
		.dqs_edge_ok_out, .par_rsp_late_out);
	ddr4_device_model dev (.mclk_in, .rst_in, .par_err_in(par), .crc_err_in(crc),
		.alert_n_out(alert_n_in));
	task test_done; begin
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end endtask
	task check(input [31:0] seen, input [31:0] exp); begin
		checks = checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end endtask
	task wt(input integer s); begin
		while (sig[s] !== 1'b1 && n < 2000) begin
			@(posedge mclk_in);
			#1 n = n + 1;
		end
		if (n >= 2000) begin
			check(0, 1);
			test_done;
		end
	end endtask
	task issue(input [2:0] c, input [2:0] nx); begin
		@(posedge mclk_in);
		cmd_valid_in <= 1;
		cmd_in <= c;
		#1 check(cmd_issue_out, 1);
		@(posedge mclk_in);
		cmd_valid_in <= 0;
		wlvl_mrs_in <= 0;
		cmd_in <= nx;
		#1 n = 0;
	end endtask
	task s_refresh; begin
		for (i = 0; i < 3; i = i + 1) begin
			fgr_mode_in <= i[1:0];
			issue(`CMD_REF, `CMD_ACT);
			wt(0);
			check(n, (i == 0) ? 18 : (i == 1) ? 13 : 8);
		end
	end endtask
	task s_level; begin
		wlvl_mrs_in <= 1;
		issue(`CMD_MRS, `CMD_ACT);
		wt(1);
		check(n, 25);
		wt(2);
		check(n, 40);
		issue(`CMD_MRS, `CMD_ACT);
		wt(0);
		check(n, 24);
	end endtask
	task s_pde; begin
		for (i = 0; i < 5; i = i + 1) begin
			bc4_fixed_in <= (i == 1 || i == 4);
			crc_dm_in <= (i == 2);
			issue((i > 2) ? `CMD_WRA : `CMD_WR, `CMD_PDE);
			wt(0);
			check(n, PDX[i*8 +: 8]);
		end
	end endtask
	task s_dll; begin
		@(posedge mclk_in);
		dll_relock_in <= 1;
		cmd_in <= `CMD_RD;
		@(posedge mclk_in);
		dll_relock_in <= 0;
		#1 n = 0;
		wt(0);
		check(n, `DLL_LOCK_CYC);
	end endtask
	task s_alert; begin
		@(posedge mclk_in);
		persist_par_in <= 1;
		par <= 1;
		@(posedge mclk_in);
		par <= 0;
		#1 n = 1;
		wt(3);
		check(n <= 4 && cmd_ready_out === 1'b0, 1);
		wt(4);
		check(n >= 88 && par_rsp_late_out === 1'b0, 1);
		persist_par_in <= 0;
		crc <= 1;
		@(posedge mclk_in);
		crc <= 0;
		repeat (12) @(posedge mclk_in);
		#1 check(deselect_out, 0);
	end endtask
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_in <= 0;
		#1 check({cmd_ready_out, deselect_out, dqs_drive_en_out, par_rsp_late_out}, 8);
		s_refresh;
		s_level;
		s_pde;
		s_dll;
		s_alert;
		test_done;
	end
endmodule // cmd_timing_guard_tb_top
bind cmd_timing_guard cmd_timing_guard_assertions u_chk (.mclk_in, .rst_in, .cmd_valid_in,
	.wlvl_mrs_in, .persist_par_in, .dll_relock_in, .alert_n_in, .cmd_ready_out,
	.cmd_issue_out, .deselect_out, .dqs_drive_en_out, .dqs_edge_ok_out,
	.par_rsp_late_out, .cmd_in, .fgr_mode_in);
